// file: src/encoder_emulation_consts.svh
// Named constants for the encoder emulation output block.
`ifndef ENCODER_EMULATION_CONSTS_SVH
`define ENCODER_EMULATION_CONSTS_SVH
`define AXI_ADDR_W       8
`define REG_CTRL         8'h00
`define REG_PPR          8'h04
`define REG_ZERO_OFFSET  8'h08
`define REG_POSITION     8'h0c
`define REG_STATUS       8'h10
`define REG_SSI_TIMEOUT  8'h14
`define CTRL_MODE_BIT    0
`define CTRL_GRAY_BIT    1
`define CTRL_DIR_BIT     2
`define CTRL_FB_BIT      3
`define CTRL_SAFETY_BIT  4
`define CTRL_TURNS_LSB   8
`define CTRL_RESET       32'h0000_0000
`define PPR_RESET        20'h00400
`define PPR_RES_MIN      20'h00020
`define PPR_RES_MAX      20'h01000
`define PPR_ENC_MIN      20'h00100
`define PPR_ENC_MAX      20'h80000
`define PPR_SAFE_MAX     20'h01000
`define TURNS_MIN        5'h0c
`define TURNS_MAX        5'h10
`define SSI_WORD_BITS    6'h20
`define SSI_TIMEOUT_RST  16'h0028
`define ONE_TURN_W       16
`define PHASE_FRAC_W     20
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: src/encoder_emulation_pkg.sv
// Types shared by the encoder emulation output block.
package encoder_emulation_pkg;
   typedef enum logic [1:0] {
      SSI_IDLE  = 2'b00,
      SSI_SHIFT = 2'b01,
      SSI_PAUSE = 2'b10
   } ssi_state_t;
endpackage : encoder_emulation_pkg

// file: src/encoder_emulation_output.sv
// Encoder emulation: quadrature or serial absolute position output with AXI4-Lite setup.
// What this block does
// - In quadrature mode the block emits incremental pulses derived from the absolute position.
// - Pulse transitions are derived from the change of the absolute shaft position.
// - Two channels A and B are driven a quarter period apart.
// - A zero pulse appears once per turn and only while A and B are both high.
// - Pulses per turn are settable, 32 to 4096 for resolver and 256 to 524288 for encoder.
// - With a safety card only powers of two up to 4096 are accepted.
// - The zero pulse sits at a settable offset within one turn.
// - By default both outputs count up for clockwise rotation.
// - In serial mode the position is given as a synchronous serial absolute word.
// - The serial word is at most 32 bits long.
// - The word opens with the turn count, 12 to 16 bits wide.
// - A fixed 16-bit single-turn field follows the turn count.
// - The word is sent in Gray or plain binary as configured.
// - The reading party supplies the serial clock and the block follows its rate.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "encoder_emulation_consts.svh"
module encoder_emulation_output
   import encoder_emulation_pkg::*;
(
   // Clock and reset.
   input  wire logic                   core_clk_i,
   input  wire logic                   reset_i,
   // Shaft position from the feedback path.
   input  wire logic [15:0]            one_turn_pos_i,
   input  wire logic [15:0]            turn_count_i,
   // AXI4-Lite slave.
   input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Output connector.
   output logic                        inc_a_o,
   output logic                        inc_b_o,
   output logic                        zero_reference_pulse_o,
   input  wire logic                   ssi_clk_i,
   output logic                        ssi_data_o
);
   // Register state.
   logic [31:0] ctrl, next_ctrl;
   logic [19:0] ppr, next_ppr;
   logic [15:0] zero_pulse_offset, next_zero_pulse_offset;
   logic [15:0] ssi_timeout, next_ssi_timeout;
   logic        ppr_reject, next_ppr_reject;
   logic        aw_held, next_aw_held, w_held, next_w_held;
   logic [`AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        bvalid, next_bvalid;
   logic [1:0]  bresp, next_bresp;
   logic        rvalid, next_rvalid;
   logic [1:0]  rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   logic        position_output_mode;
   logic        gray_sel;
   logic        reverse_dir;
   logic        feedback_source_type;
   logic        safety_card;
   logic [4:0]  turns_bits;

   assign position_output_mode = ctrl[`CTRL_MODE_BIT];
   assign gray_sel             = ctrl[`CTRL_GRAY_BIT];
   assign reverse_dir          = ctrl[`CTRL_DIR_BIT];
   assign feedback_source_type = ctrl[`CTRL_FB_BIT];
   assign safety_card          = ctrl[`CTRL_SAFETY_BIT];
   assign turns_bits           = ctrl[`CTRL_TURNS_LSB +: 5];

   // Position seen by both outputs, mirrored when the count direction is reversed.
   logic [31:0] abs_pos;
   assign abs_pos = reverse_dir ? (32'h0 - {turn_count_i, one_turn_pos_i})
                                : {turn_count_i, one_turn_pos_i};

   // Candidate pulses-per-turn check, applied to a register write.
   function automatic logic ppr_ok(input logic [31:0] v, input logic fb, input logic safe);
      logic ok;
      ok = 1'b1;
      if (v[31:20] != 12'h0) begin
         ok = 1'b0;
      end else if (!fb) begin
         ok = (v[19:0] >= `PPR_RES_MIN) && (v[19:0] <= `PPR_RES_MAX);
      end else begin
         ok = (v[19:0] >= `PPR_ENC_MIN) && (v[19:0] <= `PPR_ENC_MAX);
      end
      if (safe && ((v[19:0] > `PPR_SAFE_MAX) || ((v[19:0] & (v[19:0] - 20'h1)) != 20'h0))) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : ppr_ok

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // AXI4-Lite slave next state.
   logic        do_write;
   logic [31:0] status_word;
   logic        ssi_busy;
   logic [31:0] turns_mask;
   assign do_write      = aw_held && w_held && !bvalid;
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rresp   = rresp;
   assign s_axi_rdata   = rdata;
   assign status_word   = {29'h0, ssi_busy, ppr_reject, position_output_mode};

   always_comb begin
      logic [31:0] cand;
      cand                   = 32'h0;
      next_ctrl              = ctrl;
      next_ppr               = ppr;
      next_zero_pulse_offset = zero_pulse_offset;
      next_ssi_timeout       = ssi_timeout;
      next_ppr_reject        = ppr_reject;
      next_aw_held           = aw_held;
      next_aw_addr           = aw_addr;
      next_w_held            = w_held;
      next_w_data            = w_data;
      next_w_strb            = w_strb;
      next_bvalid            = bvalid;
      next_bresp             = bresp;
      next_rvalid            = rvalid;
      next_rresp             = rresp;
      next_rdata             = rdata;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = `RESP_OKAY;
         unique case ({aw_addr[`AXI_ADDR_W-1:2], 2'b00})
            `REG_CTRL: begin
               cand = merge(ctrl, w_data, w_strb);
               if (cand[`CTRL_TURNS_LSB +: 5] < `TURNS_MIN ||
                   cand[`CTRL_TURNS_LSB +: 5] > `TURNS_MAX) begin
                  cand[`CTRL_TURNS_LSB +: 5] = turns_bits;
               end
               next_ctrl = cand;
            end
            `REG_PPR: begin
               cand = merge({12'h0, ppr}, w_data, w_strb);
               if (ppr_ok(cand, feedback_source_type, safety_card)) begin
                  next_ppr        = cand[19:0];
                  next_ppr_reject = 1'b0;
               end else begin
                  next_ppr_reject = 1'b1;
                  next_bresp      = `RESP_SLVERR;
               end
            end
            `REG_ZERO_OFFSET: begin
               cand                   = merge({16'h0, zero_pulse_offset}, w_data, w_strb);
               next_zero_pulse_offset = cand[15:0];
            end
            `REG_SSI_TIMEOUT: begin
               cand             = merge({16'h0, ssi_timeout}, w_data, w_strb);
               next_ssi_timeout = (cand[15:0] == 16'h0) ? 16'h1 : cand[15:0];
            end
            default: next_bresp = `RESP_SLVERR;
         endcase
      end
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp  = `RESP_OKAY;
         unique case ({s_axi_araddr[`AXI_ADDR_W-1:2], 2'b00})
            `REG_CTRL:        next_rdata = ctrl;
            `REG_PPR:         next_rdata = {12'h0, ppr};
            `REG_ZERO_OFFSET: next_rdata = {16'h0, zero_pulse_offset};
            `REG_POSITION:    next_rdata = abs_pos;
            `REG_STATUS:      next_rdata = status_word;
            `REG_SSI_TIMEOUT: next_rdata = {16'h0, ssi_timeout};
            default: begin
               next_rdata = 32'h0;
               next_rresp = `RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctrl              <= `CTRL_RESET | (32'(`TURNS_MIN) << `CTRL_TURNS_LSB);
         ppr               <= `PPR_RESET;
         zero_pulse_offset <= 16'h0;
         ssi_timeout       <= `SSI_TIMEOUT_RST;
         ppr_reject        <= 1'b0;
         aw_held           <= 1'b0;
         aw_addr           <= '0;
         w_held            <= 1'b0;
         w_data            <= 32'h0;
         w_strb            <= 4'h0;
         bvalid            <= 1'b0;
         bresp             <= `RESP_OKAY;
         rvalid            <= 1'b0;
         rresp             <= `RESP_OKAY;
         rdata             <= 32'h0;
      end else begin
         ctrl              <= next_ctrl;
         ppr               <= next_ppr;
         zero_pulse_offset <= next_zero_pulse_offset;
         ssi_timeout       <= next_ssi_timeout;
         ppr_reject        <= next_ppr_reject;
         aw_held           <= next_aw_held;
         aw_addr           <= next_aw_addr;
         w_held            <= next_w_held;
         w_data            <= next_w_data;
         w_strb            <= next_w_strb;
         bvalid            <= next_bvalid;
         bresp             <= next_bresp;
         rvalid            <= next_rvalid;
         rresp             <= next_rresp;
         rdata             <= next_rdata;
      end
   end

   // Quadrature emulation. The target edge count per turn is 4 * ppr; the shaft angle is
   // scaled to that count and the output state chases it one edge per clock, which keeps
   // each step a single-channel change even when the shaft jumps.
   logic [37:0] scaled;
   logic [21:0] target_q;
   logic [21:0] edge_cnt, next_edge_cnt;
   logic [21:0] edges_per_turn;
   logic [21:0] diff;
   logic        inc_a, next_inc_a, inc_b, next_inc_b, zero_p, next_zero_p;
   logic [21:0] zero_edge;
   logic [37:0] zero_prod;
   assign edges_per_turn = {ppr, 2'b00};
   assign scaled         = abs_pos[15:0] * {16'h0, edges_per_turn};
   assign target_q       = scaled[`ONE_TURN_W +: 22];
   assign diff           = target_q - edge_cnt;
   // The full product is kept so a large offset times a fine resolution cannot wrap.
   assign zero_prod      = {22'h0, zero_pulse_offset} * {16'h0, edges_per_turn};
   assign zero_edge      = {zero_prod[37:18], 2'b10};

   always_comb begin
      logic [1:0] ph;
      ph            = 2'b00;
      next_edge_cnt = edge_cnt;
      if (diff != 22'h0) begin
         if (diff < {1'b0, edges_per_turn[21:1]}) begin
            next_edge_cnt = (edge_cnt == edges_per_turn - 22'h1) ? 22'h0 : edge_cnt + 22'h1;
         end else begin
            next_edge_cnt = (edge_cnt == 22'h0) ? edges_per_turn - 22'h1 : edge_cnt - 22'h1;
         end
      end
      // Phase 0..3 gives A,B = 00,10,11,01: B lags A going up.
      ph          = next_edge_cnt[1:0];
      next_inc_a  = ph[0] ^ ph[1];
      next_inc_b  = ph[1];
      next_zero_p = (next_edge_cnt == zero_edge);
      if (!position_output_mode) begin
         next_inc_a  = 1'b0;
         next_inc_b  = 1'b0;
         next_zero_p = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         edge_cnt <= 22'h0;
         inc_a    <= 1'b0;
         inc_b    <= 1'b0;
         zero_p   <= 1'b0;
      end else begin
         edge_cnt <= next_edge_cnt;
         inc_a    <= next_inc_a;
         inc_b    <= next_inc_b;
         zero_p   <= next_zero_p;
      end
   end
   assign inc_a_o                = inc_a;
   assign inc_b_o                = inc_b;
   assign zero_reference_pulse_o = zero_p;

   // Serial absolute output. The external clock is synchronised and its edges found here,
   // so any reader rate well below the core clock is followed while each clock half-period stays under ssi_timeout.
   logic        sclk_s1, sclk_s2, sclk_d;
   ssi_state_t  ssi_state, next_ssi_state;
   logic [31:0] ssi_word, next_ssi_word;
   logic [5:0]  bit_left, next_bit_left;
   logic [15:0] idle_cnt, next_idle_cnt;
   logic        sdata, next_sdata;
   logic        sclk_fall, sclk_rise;
   logic [31:0] packed_word;
   assign sclk_fall = sclk_d && !sclk_s2;
   assign sclk_rise = !sclk_d && sclk_s2;
   assign ssi_busy  = (ssi_state != SSI_IDLE);

   always_comb begin
      logic [31:0] w;
      w = ({16'h0, abs_pos[31:16]} & ((32'h1 << turns_bits) - 32'h1)) << `ONE_TURN_W;
      w = w | {16'h0, abs_pos[15:0]};
      if (gray_sel) begin
         w = w ^ (w >> 1);
      end
      packed_word = w << (6'(`SSI_WORD_BITS) - 6'(`ONE_TURN_W) - {1'b0, turns_bits});
   end

   always_comb begin
      next_ssi_state = ssi_state;
      next_ssi_word  = ssi_word;
      next_bit_left  = bit_left;
      next_sdata     = sdata;
      next_idle_cnt  = (sclk_fall || sclk_rise) ? 16'h0 :
                       (idle_cnt == 16'hffff)   ? idle_cnt : idle_cnt + 16'h1;
      unique case (ssi_state)
         SSI_IDLE: begin
            next_sdata = 1'b1;
            if (sclk_fall && !position_output_mode) begin
               next_ssi_word  = packed_word;
               next_bit_left  = 6'(`ONE_TURN_W) + {1'b0, turns_bits};
               next_ssi_state = SSI_SHIFT;
            end
         end
         SSI_SHIFT: begin
            if (sclk_rise) begin
               next_sdata    = ssi_word[31];
               next_ssi_word = {ssi_word[30:0], 1'b0};
               next_bit_left = bit_left - 6'h1;
               if (bit_left == 6'h1) begin
                  next_ssi_state = SSI_PAUSE;
               end
            end else if (idle_cnt >= ssi_timeout) begin
               next_ssi_state = SSI_PAUSE;
            end
         end
         SSI_PAUSE: begin
            if (sclk_rise) begin
               next_sdata = 1'b0;
            end
            if (idle_cnt >= ssi_timeout) begin
               next_sdata     = 1'b1;
               next_ssi_state = SSI_IDLE;
            end
         end
         default: next_ssi_state = SSI_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sclk_s1   <= 1'b1;
         sclk_s2   <= 1'b1;
         sclk_d    <= 1'b1;
         ssi_state <= SSI_IDLE;
         ssi_word  <= 32'h0;
         bit_left  <= 6'h0;
         idle_cnt  <= 16'h0;
         sdata     <= 1'b1;
      end else begin
         sclk_s1   <= ssi_clk_i;
         sclk_s2   <= sclk_s1;
         sclk_d    <= sclk_s2;
         ssi_state <= next_ssi_state;
         ssi_word  <= next_ssi_word;
         bit_left  <= next_bit_left;
         idle_cnt  <= next_idle_cnt;
         sdata     <= next_sdata;
      end
   end
   assign ssi_data_o = sdata;
endmodule : encoder_emulation_output

// file: tb/encoder_emulation_output_asserts.sv
// Port-level assertion checker for the encoder emulation output block.
`timescale 1ns/10ps
module encoder_emulation_output_asserts (
   // Clock and reset.
   input wire logic        core_clk_i,
   input wire logic        reset_i,
   // Register bus handshakes.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Output connector.
   input wire logic        inc_a_o,
   input wire logic        inc_b_o,
   input wire logic        zero_reference_pulse_o,
   input wire logic        ssi_clk_i,
   input wire logic        ssi_data_o
);
   logic       clk_d;
   logic       next_clk_d;
   logic [7:0] since_edge;
   logic [7:0] next_since_edge;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // Core clocks since the serial clock last moved; data that changes far from any
   // serial edge, and before the idle timeout, means the shifter ran on its own.
   always_comb begin
      next_clk_d      = ssi_clk_i;
      next_since_edge = since_edge;
      if (reset_i) begin
         next_since_edge = 8'hff;
      end else if (ssi_clk_i != clk_d) begin
         next_since_edge = 8'h00;
      end else if (since_edge != 8'hff) begin
         next_since_edge = since_edge + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      clk_d      <= next_clk_d;
      since_edge <= next_since_edge;
   end

   chk_ab_one_step: assert property (!($changed(inc_a_o) && $changed(inc_b_o)))
      else $error("A and B changed in the same cycle");
   chk_zero_in_high: assert property (zero_reference_pulse_o |-> inc_a_o && inc_b_o)
      else $error("zero pulse outside the A and B high phase");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
   chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
      |-> s_axi_rdata == 32'h0) else $error("error read returns data");
   chk_data_near_edge: assert property ($changed(ssi_data_o) |->
      since_edge <= 8'd8 || since_edge >= 8'd40) else $error("serial data moved unclocked");
   chk_data_idle_high: assert property (since_edge >= 8'd60 |-> ssi_data_o)
      else $error("serial data not idle high");
endmodule : encoder_emulation_output_asserts

bind encoder_emulation_output encoder_emulation_output_asserts i_encoder_emulation_output_asserts (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .inc_a_o(inc_a_o), .inc_b_o(inc_b_o),
   .zero_reference_pulse_o(zero_reference_pulse_o), .ssi_clk_i(ssi_clk_i),
   .ssi_data_o(ssi_data_o));

// file: tb/ssi_reader.sv
// Behavioural serial position reader that clocks frames out of the block.
`timescale 1ns/10ps
module ssi_reader (
   // Serial link.
   output logic      ssi_clk_o,
   input  wire logic ssi_data_i
);
   // The clock rests high between frames; it never runs free.
   initial begin
      ssi_clk_o = 1'b1;
   end

   // Sampling just before each rising edge leaves a full clock period for the rising-edge shift.
   task automatic read_frame(input int nbits, output logic [31:0] word);
      word = 32'h0;
      #33;
      for (int k = 0; k <= nbits; k++) begin
         ssi_clk_o = 1'b0;
         #100;
         if (k > 0) begin
            word = {word[30:0], ssi_data_i};
         end
         ssi_clk_o = 1'b1;
         #100;
      end
   endtask : read_frame
endmodule : ssi_reader

// file: tb/encoder_emulation_output_tb.sv
// Self-checking bench for the encoder emulation output block.
`timescale 1ns/10ps
`include "encoder_emulation_consts.svh"
module encoder_emulation_output_tb;
   logic                   core_clk_i, reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic                   s_axi_arvalid, s_axi_rready, ssi_clk_i, a_d, z_d;
   logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                   s_axi_rvalid, inc_a_o, inc_b_o, zero_reference_pulse_o, ssi_data_o;
   logic [15:0]            one_turn_pos_i, turn_count_i;
   logic [`AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]            s_axi_wdata, s_axi_rdata, d, w, exp_v, ppr_exp;
   logic [3:0]             s_axi_wstrb;
   logic [1:0]             s_axi_bresp, s_axi_rresp;
   int                     err_count, tests_run, a_rises, zero_rises, a0, z0;
   logic [31:0]            t_ctrl [0:7] = '{32'h0, 32'h0, 32'h8, 32'h8, 32'h18, 32'h18,
                                            32'h18, 32'h0};
   logic [31:0]            t_ppr [0:7]  = '{32'h20, 32'h1f, 32'h80000, 32'h80001, 32'h1000,
                                            32'hc00, 32'h2000, 32'h400};
   logic [7:0]             t_ok         = 8'h95;

   encoder_emulation_output i_encoder_emulation_output (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .one_turn_pos_i(one_turn_pos_i),
      .turn_count_i(turn_count_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .inc_a_o(inc_a_o), .inc_b_o(inc_b_o), .zero_reference_pulse_o(zero_reference_pulse_o),
      .ssi_clk_i(ssi_clk_i), .ssi_data_o(ssi_data_o));

   ssi_reader i_ssi_reader (.ssi_clk_o(ssi_clk_i), .ssi_data_i(ssi_data_o));

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge core_clk_i);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge core_clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 200) err_count++;
      s_axi_bready <= 1'b0;
      check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axi_write

   // Ready stands from the request on, so data are taken at the edge rvalid is seen.
   task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      int n;
      @(posedge core_clk_i);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge core_clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 200) err_count++;
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
   endtask : axi_read

   always @(posedge core_clk_i) begin
      a_d <= inc_a_o;
      z_d <= zero_reference_pulse_o;
      if (inc_a_o === 1'b1 && a_d === 1'b0) begin
         a_rises++;
         check("B at A rise", {31'h0, inc_b_o}, 32'h0);
      end
      if (zero_reference_pulse_o === 1'b1 && z_d === 1'b0) zero_rises++;
   end

   initial begin
      #2_000_000;
      err_count++;
      print_verdict();
   end

   initial begin
      {reset_i, s_axi_wstrb} = 5'h1f;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, one_turn_pos_i} = '0;
      turn_count_i = 16'h9abc;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      axi_read(`REG_PPR, `RESP_OKAY, d);
      check("ppr reset", d, {12'h0, `PPR_RESET});
      axi_read(`REG_SSI_TIMEOUT, `RESP_OKAY, d);
      check("timeout reset", d, {16'h0, `SSI_TIMEOUT_RST});
      axi_read(8'h40, `RESP_SLVERR, d);
      check("unmapped read", d, 32'h0);
      ppr_exp = {12'h0, `PPR_RESET};
      for (int i = 0; i < 8; i++) begin
         axi_write(`REG_CTRL, t_ctrl[i], `RESP_OKAY);
         axi_write(`REG_PPR, t_ppr[i], t_ok[i] ? `RESP_OKAY : `RESP_SLVERR);
         if (t_ok[i]) ppr_exp = t_ppr[i];
         axi_read(`REG_PPR, `RESP_OKAY, d);
         check("ppr value", d, ppr_exp);
         if (!t_ok[i]) begin
            axi_read(`REG_STATUS, `RESP_OKAY, d);
            check("reject flag", {31'h0, d[1]}, 32'h1);
         end
      end
      for (int i = 0; i < 2; i++) begin
         axi_write(`REG_CTRL, i ? 32'h0000_1002 : 32'h0000_0c00, `RESP_OKAY);
         exp_v = i ? {turn_count_i, one_turn_pos_i} : {4'h0, turn_count_i[11:0], one_turn_pos_i};
         if (i) exp_v = exp_v ^ (exp_v >> 1);
         i_ssi_reader.read_frame(i ? 32 : 28, w);
         check("serial word", w, exp_v);
         repeat (60) @(posedge core_clk_i);
         check("serial idle", {31'h0, ssi_data_o}, 32'h1);
      end
      axi_read(`REG_POSITION, `RESP_OKAY, d);
      check("position up", d, {turn_count_i, one_turn_pos_i});
      axi_write(`REG_CTRL, 32'h0000_0c04, `RESP_OKAY);
      axi_read(`REG_POSITION, `RESP_OKAY, d);
      check("position down", d, 32'h6544_0000);
      axi_write(`REG_ZERO_OFFSET, 32'h0000_0100, `RESP_OKAY);
      axi_write(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
      a0 = a_rises;
      z0 = zero_rises;
      @(posedge core_clk_i);
      // The shaft moves one output edge per 27 clocks, keeping the pulse rate under the limit.
      for (int p = 16; p < 32768; p += 16) begin
         one_turn_pos_i <= 16'(p);
         repeat (27) @(posedge core_clk_i);
      end
      repeat (10) @(posedge core_clk_i);
      check("A rises", a_rises - a0, 32'd512);
      check("zero pulses", zero_rises - z0, 32'd1);
      print_verdict();
   end
endmodule : encoder_emulation_output_tb
